/* hdl/lsoc_top.sv */
// line sync processing: polarity detect, phase stepped pixel clock, line sync output, coast
// assumes an APB master on clock; line_sync_in and vsync_in are asynchronous pins
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

module lsoc_top
#(
	parameter logic [7:0] REVISION = 8'h5A     // arbitrary value
)
(
	input  wire logic                   clock,
	input  wire logic                   sys_rst,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   line_sync_in,
	input  wire logic                   vsync_in,
	input  wire logic [`LSOC_PIX_W-1:0] pixel_in,
	output logic [`LSOC_PIX_W-1:0]      pixel_data_out,
	output logic                        pixel_data_clock_out,
	output logic                        line_sync_out,
	output logic                        pll_coast
);

	lsoc_pkg::lsoc_core_s q;
	lsoc_pkg::lsoc_core_s d;

	localparam lsoc_pkg::lsoc_core_s RST = '{
		div_hi:    `LSOC_RST_DIV_HI,
		div_lo:    `LSOC_RST_DIV_LO,
		phase:     `LSOC_RST_PHASE,
		width:     `LSOC_RST_WIDTH,
		sync_ctl:  `LSOC_RST_SYNC_CTL,
		coast_ctl: `LSOC_RST_COAST_CTL,
		ls_state:  lsoc_pkg::LSOC_LS_IDLE,
		default:   '0
	};

	logic        setup;
	logic        access;
	logic [5:0]  idx;
	logic        mapped;
	logic [11:0] div;
	logic        in_pol;
	logic        act_now;
	logic        act_prev;
	logic        lead;
	logic        missing;
	logic        coast;
	logic        ref_pll;
	logic [17:0] inc;
	logic [18:0] sum;
	logic [18:0] per;
	logic [18:0] rem;
	logic        sample;
	logic        out_act;

	// *************************************************
	// bus decode
	// *************************************************
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign idx = paddr[7:2];
	assign mapped = (paddr[1:0] == 2'h0) &&
		((idx == `LSOC_IDX_REV) || (idx == `LSOC_IDX_DIV_HI) ||
		(idx == `LSOC_IDX_DIV_LO) || (idx == `LSOC_IDX_PHASE) ||
		(idx == `LSOC_IDX_WIDTH) || (idx == `LSOC_IDX_SYNC_CTL) ||
		(idx == `LSOC_IDX_COAST_CTL) || (idx == `LSOC_IDX_STATUS) ||
		(idx == `LSOC_IDX_PERIOD));
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = q.prdata;

	// *************************************************
	// sync processing
	// *************************************************
	assign div = {q.div_hi, q.div_lo[7:4]};
	// manual polarity is trusted as written
	assign in_pol = q.sync_ctl[`LSOC_SYNC_MANUAL] ? q.sync_ctl[`LSOC_SYNC_IN_POL] : q.pol_high;
	assign act_now = in_pol ? q.ls_s : ~q.ls_s;
	assign act_prev = in_pol ? q.ls_p : ~q.ls_p;
	assign lead = act_now & ~act_prev;
	assign missing = (q.period != 16'h0000) && ({1'b0, q.cnt} > {q.period, 1'b0});
	// internal coast; with all enables clear the reference always passes
	assign coast = q.coast_ctl[`LSOC_COAST_EN] &
		((q.coast_ctl[`LSOC_COAST_VSYNC] & q.vs_s) |
		(q.coast_ctl[`LSOC_COAST_MISS] & missing));
	assign ref_pll = lead & ~q.coast;
	// 32 steps per pixel, pixels per line = divider + 1
	assign inc = {6'h00, div} + 18'h00001;
	assign sum = {1'b0, q.acc} + {inc[13:0], 5'h00};
	assign per = {3'h0, q.period};
	assign rem = sum - per;

	lsoc_phase_gen u_phase
	(
		.clock     (clock),
		.sys_rst   (sys_rst),
		.step_tick (q.step_tick),
		.resync    (ref_pll),
		.phase     (q.phase[7:`LSOC_PHASE_LSB]),
		.sample    (sample),
		.clk_out   (pixel_data_clock_out)
	);

	always_comb
	begin
		d = q;
		out_act = 1'b0;
		// *************************************************
		// pin synchronisers
		// *************************************************
		d.ls_m = line_sync_in;
		d.ls_s = q.ls_m;
		d.ls_p = q.ls_s;
		d.vs_m = vsync_in;
		d.vs_s = q.vs_m;
		d.coast = coast;

		// *************************************************
		// register access
		// *************************************************
		if (setup)
		begin
			d.prdata = 32'h00000000;
			case (idx)
				`LSOC_IDX_REV:       d.prdata[7:0] = REVISION;
				`LSOC_IDX_DIV_HI:    d.prdata[7:0] = q.div_hi;
				`LSOC_IDX_DIV_LO:    d.prdata[7:0] = {q.div_lo[7:4], 4'h0};
				`LSOC_IDX_PHASE:     d.prdata[7:0] = {q.phase[7:3], 3'h0};
				`LSOC_IDX_WIDTH:     d.prdata[7:0] = q.width;
				`LSOC_IDX_SYNC_CTL:  d.prdata[7:0] = {q.sync_ctl[7:5], 5'h00};
				`LSOC_IDX_COAST_CTL: d.prdata[7:0] = {4'h0, q.coast_ctl[3:1], 1'b0};
				`LSOC_IDX_STATUS:
				begin
					d.prdata[`LSOC_ST_POL_HIGH] = in_pol;
					d.prdata[`LSOC_ST_COAST] = q.coast;
					d.prdata[`LSOC_ST_MISSING] = missing;
					d.prdata[`LSOC_ST_DIV_LOW] = div < `LSOC_DIV_MIN;
				end
				`LSOC_IDX_PERIOD:    d.prdata[15:0] = q.period;
				default:             d.prdata = 32'h00000000;
			endcase
		end
		if (access && pwrite && mapped)
		begin
			case (idx)
				`LSOC_IDX_DIV_HI:    d.div_hi = pwdata[7:0];
				`LSOC_IDX_DIV_LO:    d.div_lo = {pwdata[7:4], 4'h0};
				`LSOC_IDX_PHASE:     d.phase = {pwdata[7:3], 3'h0};
				`LSOC_IDX_WIDTH:     d.width = pwdata[7:0];
				`LSOC_IDX_SYNC_CTL:  d.sync_ctl = {pwdata[7:5], 5'h00};
				`LSOC_IDX_COAST_CTL: d.coast_ctl = {4'h0, pwdata[3:1], 1'b0};
				default:             d.coast_ctl = q.coast_ctl;
			endcase
		end

		// *************************************************
		// line period and polarity measurement
		// *************************************************
		d.cnt = (&q.cnt) ? q.cnt : q.cnt + 16'h0001;
		d.high_cnt = (&q.high_cnt) ? q.high_cnt : q.high_cnt + {15'h0000, q.ls_s};
		if (lead)
		begin
			// the active part of a line is the shorter one
			d.pol_high = q.high_cnt < {1'b0, q.cnt[15:1]};
			d.cnt = 16'h0001;
			d.high_cnt = {15'h0000, q.ls_s};
		end
		if (ref_pll)
		begin
			d.period = q.cnt;
		end

		// *************************************************
		// pixel rate generator, at most one step per clock
		// *************************************************
		d.step_tick = 1'b0;
		if (ref_pll)
		begin
			d.acc = 18'h00000;
		end
		else if (q.period == 16'h0000)
		begin
			d.acc = 18'h00000;
		end
		else if (sum >= per)
		begin
			d.acc = (rem >= per) ? 18'h00000 : rem[17:0];
			d.step_tick = 1'b1;
		end
		else
		begin
			d.acc = sum[17:0];
		end

		// *************************************************
		// line sync output
		// *************************************************
		case (q.ls_state)
			lsoc_pkg::LSOC_LS_IDLE:
			begin
				if (lead)
				begin
					d.ls_state = lsoc_pkg::LSOC_LS_PEND;
				end
			end
			lsoc_pkg::LSOC_LS_PEND:
			begin
				if (sample)
				begin
					// start on the same strobe that moves pixel data
					d.ls_state = lsoc_pkg::LSOC_LS_PULSE;
					d.ls_cnt = (q.width == 8'h00) ? 8'h01 : q.width;
				end
			end
			lsoc_pkg::LSOC_LS_PULSE:
			begin
				if (sample)
				begin
					if (q.ls_cnt == 8'h01)
					begin
						d.ls_state = lsoc_pkg::LSOC_LS_IDLE;
					end
					else
					begin
						d.ls_cnt = q.ls_cnt - 8'h01;
					end
				end
			end
			default:
			begin
				d.ls_state = lsoc_pkg::LSOC_LS_IDLE;
			end
		endcase
		out_act = (d.ls_state == lsoc_pkg::LSOC_LS_PULSE);
		d.ls_lvl = q.sync_ctl[`LSOC_SYNC_OUT_POL] ? out_act : ~out_act;
		if (sample)
		begin
			d.pix = pixel_in;
		end
	end

	assign pixel_data_out = q.pix;
	assign line_sync_out = q.ls_lvl;
	assign pll_coast = q.coast;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q <= RST;
		end
		else
		begin
			q <= d;
		end
	end

endmodule

`default_nettype wire

/* hdl/lsoc_regs.svh */
// register map, field positions and reset values of the line sync output block
// assumes the includer addresses registers by word index, byte address = 4 * index
// What this block does
// - pixel data clock rises midway between pixel data output transitions
// - sampling phase versus line sync adjustable over full cycle in 32 steps
// - each phase step is 11.25 degrees; line sync output shifts likewise
// - incoming line sync is the reference for the pixel sampling clock
// - feedback divider divides by programmed 12-bit value plus one, 221..4095
// - input line sync polarity is detected so the output polarity is known
// - line sync output active high or low from sync control bit 5
// - line sync output aligned with pixel data clock and pixel data
// - line sync output pulse lasts the programmed number of pixel clocks, one pixel clock when width is zero
// - coast is generated internally by the sync processing logic
// - while coasting the PLL reference is blocked, pixel rate held
`ifndef LSOC_REGS_SVH
`define LSOC_REGS_SVH

// *************************************************
// register indices
// *************************************************
`define LSOC_IDX_REV        6'h00
`define LSOC_IDX_DIV_HI     6'h01
`define LSOC_IDX_DIV_LO     6'h02
`define LSOC_IDX_PHASE      6'h04
`define LSOC_IDX_WIDTH      6'h07
`define LSOC_IDX_SYNC_CTL   6'h10
`define LSOC_IDX_COAST_CTL  6'h11
`define LSOC_IDX_STATUS     6'h12
`define LSOC_IDX_PERIOD     6'h13

// *************************************************
// reset values
// *************************************************
`define LSOC_RST_DIV_HI     8'h69
`define LSOC_RST_DIV_LO     8'hD0
`define LSOC_RST_PHASE      8'h80
`define LSOC_RST_WIDTH      8'h20
`define LSOC_RST_SYNC_CTL   8'h20
`define LSOC_RST_COAST_CTL  8'h00

// *************************************************
// field positions
// *************************************************
`define LSOC_PHASE_LSB      3
`define LSOC_SYNC_MANUAL    7
`define LSOC_SYNC_IN_POL    6
`define LSOC_SYNC_OUT_POL   5
`define LSOC_COAST_EN       1
`define LSOC_COAST_MISS     2
`define LSOC_COAST_VSYNC    3
`define LSOC_ST_POL_HIGH    0
`define LSOC_ST_COAST       1
`define LSOC_ST_MISSING     2
`define LSOC_ST_DIV_LOW     3

// *************************************************
// limits and counts
// *************************************************
`define LSOC_DIV_MIN        12'h0DD
`define LSOC_HALF_CYCLE     5'h10
`define LSOC_PIX_W          24

`endif

/* hdl/lsoc_pkg.sv */
// types of the line sync output block
// assumes lsoc_regs.svh is on the include path
`default_nettype none
`include "lsoc_regs.svh"

package lsoc_pkg;

	typedef enum logic [1:0] {LSOC_LS_IDLE, LSOC_LS_PEND, LSOC_LS_PULSE} lsoc_ls_e;

	typedef struct packed {
		logic [4:0] step;
		logic       clk;
	} lsoc_phase_s;

	typedef struct packed {
		logic                   ls_m;
		logic                   ls_s;
		logic                   ls_p;
		logic                   vs_m;
		logic                   vs_s;
		logic [7:0]             div_hi;
		logic [7:0]             div_lo;
		logic [7:0]             phase;
		logic [7:0]             width;
		logic [7:0]             sync_ctl;
		logic [7:0]             coast_ctl;
		logic [31:0]            prdata;
		logic [15:0]            cnt;
		logic [15:0]            high_cnt;
		logic [15:0]            period;
		logic                   pol_high;
		logic                   coast;
		logic [17:0]            acc;
		logic                   step_tick;
		lsoc_ls_e               ls_state;
		logic [7:0]             ls_cnt;
		logic                   ls_lvl;
		logic [`LSOC_PIX_W-1:0] pix;
	} lsoc_core_s;

endpackage

`default_nettype wire

/* hdl/lsoc_phase_gen.sv */
// phase step counter: 32 steps per pixel period, sample strobe and pixel data clock
// assumes step_tick and resync come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none

module lsoc_phase_gen
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       step_tick,
	input  wire logic       resync,
	input  wire logic [4:0] phase,
	output logic            sample,
	output logic            clk_out
);

	lsoc_pkg::lsoc_phase_s q;
	lsoc_pkg::lsoc_phase_s d;
	logic [4:0]            nstep;
	logic [4:0]            diff;

	// *************************************************
	// step counter
	// *************************************************
	always_comb
	begin
		d = q;
		nstep = q.step;
		if (resync)
		begin
			nstep = 5'h00;
		end
		else if (step_tick)
		begin
			nstep = q.step + 5'h01;
		end
		diff = nstep - phase;
		// data moves at diff 0, clock rises at diff 16: half a pixel later
		d.clk = diff[4];
		d.step = nstep;
	end

	assign sample = step_tick & ~resync & ((q.step + 5'h01) == phase);
	assign clk_out = q.clk;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

endmodule

`default_nettype wire

/* bench/lsoc_top_props.sv */
// checker of the line sync output block, port level only
// assumes a bind into lsoc_top, one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "lsoc_regs.svh"

module lsoc_top_props
#(
	parameter logic [7:0] REVISION = 8'h5A
)
(
	input wire logic                   clock,
	input wire logic                   sys_rst,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   vsync_in,
	input wire logic [`LSOC_PIX_W-1:0] pixel_data_out,
	input wire logic                   pixel_data_clock_out,
	input wire logic                   line_sync_out,
	input wire logic                   pll_coast
);
	logic [7:0] sc_q;
	logic [7:0] cst_q;
	logic [7:0] wd_q;
	logic [7:0] pk_q;
	logic       ck_q;
	wire        wr_hit = psel && penable && pready && pwrite;

	// ****************************************
	// shadow of control writes, pulse counter
	// ****************************************
	// counter clears while inactive, so a polarity flip costs at most one count
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sc_q  <= `LSOC_RST_SYNC_CTL;
			cst_q <= `LSOC_RST_COAST_CTL;
			wd_q  <= `LSOC_RST_WIDTH;
			pk_q  <= 8'h00;
			ck_q  <= 1'b0;
		end
		else
		begin
			if (wr_hit && paddr == {`LSOC_IDX_SYNC_CTL, 2'b00}) sc_q <= pwdata[7:0];
			if (wr_hit && paddr == {`LSOC_IDX_COAST_CTL, 2'b00}) cst_q <= pwdata[7:0];
			if (wr_hit && paddr == {`LSOC_IDX_WIDTH, 2'b00}) wd_q <= pwdata[7:0];
			ck_q <= pixel_data_clock_out;
			if (line_sync_out != sc_q[`LSOC_SYNC_OUT_POL]) pk_q <= 8'h00;
			else if (pixel_data_clock_out && !ck_q) pk_q <= pk_q + 8'h01;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_ready_access: assert property (psel && penable |-> pready)
		else $error("access without ready");
	a_err_align: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access without error");
	a_err_idle: assert property (!(psel && penable) |-> !pslverr)
		else $error("error outside access");
	a_err_rdzero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_rev_read: assert property (psel && penable && !pwrite && paddr == 8'h00 |-> prdata == {24'h0, REVISION})
		else $error("revision read wrong");
	a_reset_idle: assert property ($fell(sys_rst) |-> prdata == 32'h0 && pixel_data_out == '0 &&
		!pixel_data_clock_out && !line_sync_out && !pll_coast)
		else $error("outputs not idle after reset");
	a_data_steady: assert property ($rose(pixel_data_clock_out) |->
		$stable(pixel_data_out) && ($stable(line_sync_out) ||
		$past(sc_q[`LSOC_SYNC_OUT_POL], 2) != $past(sc_q[`LSOC_SYNC_OUT_POL])))
		else $error("data moved at pixel clock rise");
	a_pulse_width: assert property (pk_q <= ((wd_q == 8'h00) ? 8'h01 : wd_q))
		else $error("line sync pulse too long");
	a_coast_vsync: assert property (cst_q[1] && cst_q[3] && vsync_in [*6] |-> pll_coast)
		else $error("coast missing during vsync");
	a_coast_off: assert property ((!cst_q[1]) [*3] |-> !pll_coast)
		else $error("coast while disabled");
endmodule

bind lsoc_top lsoc_top_props #(.REVISION(REVISION)) lsoc_top_props_inst
(
	.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.vsync_in(vsync_in), .pixel_data_out(pixel_data_out), .pixel_data_clock_out(pixel_data_clock_out),
	.line_sync_out(line_sync_out), .pll_coast(pll_coast)
);
`default_nettype wire

/* bench/lsoc_scaler.sv */
// scaler side model: latches pixels on the pixel clock rise, measures sync pulses
// assumes the block's outputs on the same clock; act_high gives the active level
`timescale 1ns/100ps
`default_nettype none
`include "lsoc_regs.svh"

module lsoc_scaler
(
	input  wire logic                   clock,
	input  wire logic                   sys_rst,
	input  wire logic                   act_high,
	input  wire logic                   pixel_data_clock_out,
	input  wire logic [`LSOC_PIX_W-1:0] pixel_data_out,
	input  wire logic                   line_sync_out,
	output logic      [`LSOC_PIX_W-1:0] pix_q,
	output logic      [7:0]             len_q,
	output logic                        done_q
);
	logic       ck_q;
	logic [7:0] cnt_q;
	wire        act = (line_sync_out == act_high);

	// ****************************************
	// latch and pulse length in pixel clocks
	// ****************************************
	// zero length pulses are polarity switch glitches, not reported
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ck_q   <= 1'b0;
			cnt_q  <= 8'h00;
			pix_q  <= '0;
			len_q  <= 8'h00;
			done_q <= 1'b0;
		end
		else
		begin
			ck_q   <= pixel_data_clock_out;
			done_q <= 1'b0;
			if (pixel_data_clock_out && !ck_q) pix_q <= pixel_data_out;
			if (!act)
			begin
				cnt_q <= 8'h00;
				len_q <= cnt_q;
				done_q <= (cnt_q != 8'h00);
			end
			else if (pixel_data_clock_out && !ck_q) cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* bench/lsoc_tb_top.sv */
// testbench of the line sync output block
// assumes lsoc_top, lsoc_scaler and the bound checker are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "lsoc_regs.svh"

module lsoc_tb_top;
	localparam logic [7:0] REV = 8'h3C; // arbitrary value
	logic                   clock = 1'b0;
	logic                   sys_rst = 1'b1;
	logic                   psel = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite = 1'b0;
	logic [7:0]             paddr = 8'h00;
	logic [31:0]            pwdata = 32'h0;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   line_sync_in = 1'b1;
	logic                   vsync_in = 1'b0;
	logic [`LSOC_PIX_W-1:0] pixel_in = '0;
	logic [`LSOC_PIX_W-1:0] pixel_data_out;
	logic                   pixel_data_clock_out;
	logic                   line_sync_out;
	logic                   pll_coast;
	logic [7:0]             len_q;
	logic                   done_q;
	logic [`LSOC_PIX_W-1:0] pix_q;
	logic                   hold_px = 1'b0;
	logic [31:0]            rnd = 32'd66596;
	logic                   in_hi = 1'b0;
	logic                   out_hi = 1'b1;
	logic [7:0]             exp_w;
	logic [31:0]            rq[$];
	logic [7:0]             wq[$];
	int                     num_errors = 0;
	int                     comparisons = 0;
	int                     cyc = 0;
	logic [7:0]             ra[7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1C, 8'h40, 8'h44};
	logic [31:0]            rv[7] = '{32'(REV), 32'h69, 32'hD0, 32'h80, 32'h20, 32'h20, 32'h00};
	logic [7:0]             wl[4] = '{8'h01, 8'h04, 8'h00, 8'h09};

	lsoc_top #(.REVISION(REV)) lsoc_top_inst
	(
		.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_sync_in(line_sync_in), .vsync_in(vsync_in), .pixel_in(pixel_in),
		.pixel_data_out(pixel_data_out), .pixel_data_clock_out(pixel_data_clock_out),
		.line_sync_out(line_sync_out), .pll_coast(pll_coast)
	);

	lsoc_scaler lsoc_scaler_inst
	(
		.clock(clock), .sys_rst(sys_rst), .act_high(out_hi), .pixel_data_clock_out(pixel_data_clock_out),
		.pixel_data_out(pixel_data_out), .line_sync_out(line_sync_out), .pix_q(pix_q), .len_q(len_q), .done_q(done_q)
	);

	// ****************************************
	// clock, random pixels, timeout
	// ****************************************
	always #50 clock = ~clock;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// ceiling well above the roughly 40000 cycles the sequence needs
	always @(posedge clock)
	begin
		rnd <= xs(rnd);
		if (!hold_px) pixel_in <= rnd[`LSOC_PIX_W-1:0];
		cyc = cyc + 1;
		if (cyc == 60000)
		begin
			num_errors = num_errors + 1;
			report_and_stop();
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			$display("[FAIL] %0t read %h expected %h", $time, got, exp);
			num_errors = num_errors + 1;
		end
	endtask

	task automatic cmp_w(input logic [7:0] got, input logic [7:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			$display("[FAIL] %0t width %h expected %h", $time, got, exp);
			num_errors = num_errors + 1;
		end
	endtask

	task automatic cmp_px(input logic [`LSOC_PIX_W-1:0] got, input logic [`LSOC_PIX_W-1:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			$display("[FAIL] %0t pixel %h expected %h", $time, got, exp);
			num_errors = num_errors + 1;
		end
	endtask

	// entered and left right after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		apb(1'b0, a, rnd);
	endtask

	// lines of 1600 clocks with a 100 clock active part
	task automatic lines(input int n, input bit push);
		repeat (n)
		begin
			if (push) wq.push_back(exp_w);
			line_sync_in <= in_hi;
			repeat (100) @(posedge clock);
			line_sync_in <= !in_hi;
			repeat (1500) @(posedge clock);
		end
	endtask

	// ****************************************
	// result watcher
	// ****************************************
	always @(posedge clock)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) cmp_rd(prdata, rq.pop_front());
		if (done_q === 1'b1 && wq.size() > 0) cmp_w(len_q, wq.pop_front());
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		foreach (ra[i]) rd(ra[i], rv[i]);
		rd(8'h0C, 32'h0);
		apb(1'b1, 8'h00, 32'hFF);
		rd(8'h00, 32'(REV));
		apb(1'b1, 8'h1D, 32'h05);
		rd(8'h1C, 32'h20);
		for (int p = 1; p < 32; p += 10)
		begin
			apb(1'b1, 8'h10, 32'(p << 3));
			rd(8'h10, 32'(p << 3));
		end
		lines(3, 1'b0);
		foreach (wl[i])
		begin
			apb(1'b1, 8'h1C, 32'(wl[i]));
			exp_w = (wl[i] == 8'h00) ? 8'h01 : wl[i];
			lines(1, 1'b0);
			lines(2, 1'b1);
		end
		rd(8'h48, 32'h0);
		rd(8'h4C, 32'd1600);
		// held input for 100 clocks: latched and output pixel must then show this word
		hold_px <= 1'b1;
		repeat (100) @(posedge clock);
		cmp_px(pix_q, pixel_in);
		cmp_px(pixel_data_out, pixel_in);
		hold_px <= 1'b0;
		in_hi = 1'b1;
		line_sync_in <= 1'b0;
		apb(1'b1, 8'h40, 32'h00);
		out_hi = 1'b0;
		lines(3, 1'b0);
		lines(2, 1'b1);
		rd(8'h48, 32'h1);
		apb(1'b1, 8'h40, 32'hE0);
		out_hi = 1'b1;
		lines(1, 1'b0);
		lines(2, 1'b1);
		apb(1'b1, 8'h44, 32'h0A);
		vsync_in <= 1'b1;
		repeat (8) @(posedge clock);
		rd(8'h48, 32'h3);
		vsync_in <= 1'b0;
		repeat (8) @(posedge clock);
		apb(1'b1, 8'h44, 32'h06);
		repeat (3400) @(posedge clock);
		rd(8'h48, 32'h7);
		apb(1'b1, 8'h44, 32'h00);
		repeat (8) @(posedge clock);
		apb(1'b1, 8'h04, 32'h0D);
		apb(1'b1, 8'h08, 32'h0F);
		rd(8'h08, 32'h00);
		rd(8'h48, 32'h0D);
		cmp_w(8'(wq.size()), 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
